//--- charge_switch_pkg.sv
package charge_switch_pkg;

  localparam int clk_hz = 100_000_000;
  localparam int pwm_hz = 125;
  localparam int pwm_period_cycles = clk_hz / pwm_hz;
  localparam int relay_gap_s = 30;
  localparam longint relay_gap_cycles = longint'(relay_gap_s) * clk_hz;
  localparam int slow_gap_ms = 250;
  localparam int slow_gap_cycles = (slow_gap_ms * (clk_hz / 1000));

  localparam logic [11:0] addr_ctrl = 12'h000;
  localparam logic [11:0] addr_setpoint = 12'h004;
  localparam logic [11:0] addr_measure = 12'h008;
  localparam logic [11:0] addr_status = 12'h00C;

  localparam int ctrl_sense_lsb = 0;
  localparam int ctrl_load_lsb = 2;
  localparam int ctrl_aux_lsb = 6;
  localparam int ctrl_mode_lsb = 10;
  localparam int ctrl_program_level_lsb = 12;
  localparam int ctrl_float_bit = 15;

  localparam logic [1:0] sense_select_rst = 2'h0;
  localparam logic [3:0] load_function_rst = 4'h1;
  localparam logic [3:0] aux_function_rst = 4'h2;
  localparam logic [1:0] mode_rst = 2'h3;
  localparam logic [2:0] program_level_rst = 3'h0;
  localparam logic [2:0] program_level_full = 3'h4;

  localparam logic [1:0] sense_negative = 2'h0;
  localparam logic [1:0] sense_second_battery = 2'h1;
  localparam logic [1:0] sense_external = 2'h2;

  localparam logic [3:0] fn_second_on = 4'h6;
  localparam logic [3:0] fn_second_off = 4'h7;
  localparam logic [3:0] fn_diversion = 4'hA;
  localparam logic [3:0] fn_diversion_inv = 4'hB;

  localparam logic [1:0] pwm_none = 2'h0;
  localparam logic [1:0] pwm_solar = 2'h1;
  localparam logic [1:0] pwm_load = 2'h2;
  localparam logic [1:0] pwm_both = 2'h3;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic [11:0] second_battery_setpoint;
    logic [11:0] float_voltage_setpoint;
    logic [7:0] switching_hysteresis;
  } setpoint_type;

  typedef struct packed {
    logic [11:0] battery_voltage;
    logic [11:0] external_sense_voltage;
  } measure_type;

endpackage : charge_switch_pkg

//--- charge_switch_ctrl.sv
module charge_switch_ctrl
  import charge_switch_pkg::*;
#(
  parameter longint relay_gap = relay_gap_cycles,
  parameter int slow_gap = slow_gap_cycles
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sense_closed_pin,
  output logic solar_negative_switch,
  output logic load_terminal,
  output logic aux_terminal,
  output logic push_button
);
  import charge_switch_pkg::*;

  function automatic logic terminal_drive(input logic [3:0] fn, input logic charge2, input logic reg_on);
    case (fn)
      fn_second_on: terminal_drive = charge2;
      fn_second_off: terminal_drive = !charge2;
      fn_diversion: terminal_drive = reg_on;
      fn_diversion_inv: terminal_drive = !reg_on;
      default: terminal_drive = 1'b0;
    endcase
  endfunction : terminal_drive

  logic [1:0] sense_input_select;
  logic [3:0] load_terminal_function;
  logic [3:0] aux_terminal_function;
  logic [1:0] pwm_mode;
  logic [2:0] program_level;
  logic float_state;
  setpoint_type setpoints;
  measure_type measures;
  logic [11:0] second_battery_voltage;

  logic have_aw, have_w;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  logic [31:0] relay_timer;
  logic [31:0] slow_timer;
  logic [19:0] pwm_count;
  logic [19:0] duty;
  logic charge2;
  logic slow_on;
  logic pwm_on;
  logic sense_meta, sense_sync;

  logic [12:0] relay_drop;
  logic [12:0] slow_off_level;
  logic [12:0] err;
  logic want_charge2;
  logic write_fire;
  logic load_pwm_ok;
  logic solar_pwm_ok;

  assign write_fire = have_aw && have_w && !bvalid;
  assign relay_drop = {1'b0, setpoints.float_voltage_setpoint} - {5'h00, setpoints.switching_hysteresis};
  assign slow_off_level = {1'b0, setpoints.float_voltage_setpoint} - {5'h00, setpoints.switching_hysteresis};
  // only a sense input on selection 1 yields a valid second battery reading
  assign want_charge2 = float_state && (sense_input_select == sense_second_battery)
    && (second_battery_voltage < setpoints.second_battery_setpoint)
    && !({1'b0, measures.battery_voltage} < relay_drop);
  assign solar_pwm_ok = (pwm_mode == pwm_solar) || (pwm_mode == pwm_both);
  assign load_pwm_ok = ((pwm_mode == pwm_load) || (pwm_mode == pwm_both))
    && (load_terminal_function == fn_diversion);
  assign err = {1'b0, setpoints.float_voltage_setpoint} - {1'b0, measures.battery_voltage};

  // AXI4-Lite write address and data capture, either order
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        have_aw <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (write_fire)
        have_aw <= 1'b0;
      if (wvalid && wready)
      begin
        have_w <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (write_fire)
        have_w <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      awready <= !have_aw && !(awvalid && awready) && !bvalid;
      wready <= !have_w && !(wvalid && wready) && !bvalid;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end
    else if (write_fire)
    begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_q == addr_ctrl || aw_addr_q == addr_setpoint || aw_addr_q == addr_measure)
        ? resp_okay : resp_slverr;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // control register: terminal functions locked unless at full program level
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sense_input_select <= sense_select_rst;
      load_terminal_function <= load_function_rst;
      aux_terminal_function <= aux_function_rst;
      pwm_mode <= mode_rst;
      program_level <= program_level_rst;
      float_state <= 1'b0;
    end
    else if (write_fire && aw_addr_q == addr_ctrl)
    begin
      if (w_strb_q[1])
      begin
        program_level <= w_data_q[ctrl_program_level_lsb +: 3];
        float_state <= w_data_q[ctrl_float_bit];
      end
      if (program_level == program_level_full)
      begin
        if (w_strb_q[0])
        begin
          if (w_data_q[ctrl_sense_lsb +: 2] <= sense_external)
            sense_input_select <= w_data_q[ctrl_sense_lsb +: 2];
          load_terminal_function <= {w_data_q[ctrl_load_lsb +: 4]};
        end
        if (w_strb_q[1])
        begin
          aux_terminal_function <= w_data_q[ctrl_aux_lsb +: 4];
          pwm_mode <= w_data_q[ctrl_mode_lsb +: 2];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      setpoints <= '0;
      measures <= '0;
    end
    else if (write_fire && aw_addr_q == addr_setpoint)
      setpoints <= w_data_q;
    else if (write_fire && aw_addr_q == addr_measure)
      measures <= w_data_q[23:0];
  end

  assign second_battery_voltage = measures.external_sense_voltage;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= resp_okay;
    end
    else
    begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= resp_okay;
        case (araddr)
          addr_ctrl: rdata <= {16'h0000, float_state, program_level, pwm_mode,
            aux_terminal_function, load_terminal_function, sense_input_select};
          addr_setpoint: rdata <= setpoints;
          addr_measure: rdata <= {8'h00, measures};
          addr_status: rdata <= {27'h0000000, push_button, pwm_on, slow_on, charge2, solar_negative_switch};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= resp_slverr;
          end
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // push-button closure drives the sense input high
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end
    else
    begin
      sense_meta <= sense_closed_pin;
      sense_sync <= sense_meta;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      push_button <= 1'b0;
    else
      push_button <= sense_sync && (sense_input_select == sense_external);
  end

  // second battery relay decision with minimum spacing
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      charge2 <= 1'b0;
      relay_timer <= 32'h0000_0000;
    end
    else if (relay_timer != 32'h0000_0000)
      relay_timer <= relay_timer - 32'h0000_0001;
    else if (want_charge2 != charge2)
    begin
      charge2 <= want_charge2;
      relay_timer <= 32'(relay_gap - 1);
    end
  end

  // slow on/off switching with hysteresis and minimum spacing
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slow_on <= 1'b1;
      slow_timer <= 32'h0000_0000;
    end
    else if (slow_timer != 32'h0000_0000)
      slow_timer <= slow_timer - 32'h0000_0001;
    else if (slow_on && measures.battery_voltage >= setpoints.float_voltage_setpoint)
    begin
      slow_on <= 1'b0;
      slow_timer <= 32'(slow_gap - 1);
    end
    else if (!slow_on && {1'b0, measures.battery_voltage} < slow_off_level)
    begin
      slow_on <= 1'b1;
      slow_timer <= 32'(slow_gap - 1);
    end
  end

  // fixed-frequency PWM, duty latched at period start
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_count <= 20'h00000;
      duty <= 20'h00000;
      pwm_on <= 1'b0;
    end
    else
    begin
      if (pwm_count == 20'(pwm_period_cycles - 1))
      begin
        pwm_count <= 20'h00000;
        if (err[12])
          duty <= 20'h00000;
        else if ({7'h00, err} * 20'd256 >= 20'(pwm_period_cycles))
          duty <= 20'(pwm_period_cycles);
        else
          duty <= {7'h00, err} * 20'd256;
      end
      else
        pwm_count <= pwm_count + 20'h00001;
      pwm_on <= pwm_count < duty;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      solar_negative_switch <= 1'b0;
      load_terminal <= 1'b0;
      aux_terminal <= 1'b0;
    end
    else
    begin
      solar_negative_switch <= solar_pwm_ok ? pwm_on : slow_on;
      load_terminal <= terminal_drive(load_terminal_function, charge2, load_pwm_ok ? !pwm_on : !slow_on);
      aux_terminal <= terminal_drive(aux_terminal_function, charge2, !slow_on);
    end
  end

endmodule : charge_switch_ctrl

//--- charge_switch_sva.sv
module charge_switch_sva
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sense_closed_pin,
  input wire logic push_button
);
  timeunit 1ns;
  timeprecision 1ps;
  import charge_switch_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence read_taken;
    arvalid && arready;
  endsequence
  b_answer_a: assert property (write_taken |=> !bvalid ##1 bvalid) else $error("write response late");
  r_answer_a: assert property (read_taken |=> rvalid) else $error("read response late");
  b_stands_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
  r_stands_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rvalid dropped");
  b_done_a: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
  w_busy_a: assert property (bvalid |-> !awready && !wready) else $error("write ready while busy");
  r_busy_a: assert property (rvalid |-> !arready) else $error("read ready while busy");
  slverr_zero_a: assert property (rvalid && rresp == resp_slverr |-> rdata == 32'h0) else $error("error data");
  push_sync_a: assert property (push_button |-> $past(sense_closed_pin, 2) || $past(sense_closed_pin, 3)
    || $past(sense_closed_pin, 4)) else $error("push without closure");
endmodule : charge_switch_sva

bind charge_switch_ctrl charge_switch_sva i_charge_switch_sva (.ref_clk(ref_clk), .rstn(rstn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .sense_closed_pin(sense_closed_pin), .push_button(push_button));

//--- relay_model.sv
module relay_model
(
  input wire logic ref_clk,
  input wire logic coil,
  input wire logic press,
  output logic sense_closed_pin,
  output logic on_second
);
  timeunit 1ns;
  timeprecision 1ps;
  // changeover contact follows the coil one cycle later
  always_ff @(posedge ref_clk)
    on_second <= coil;
  // switch between sense input and battery negative
  assign sense_closed_pin = press;
endmodule : relay_model

//--- test_charge_switch_and_aux_battery_control.sv
module test_charge_switch_and_aux_battery_control;
  timeunit 1ns;
  timeprecision 1ps;
  import charge_switch_pkg::*;
  logic ref_clk, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF, l, a;
  logic [1:0] bresp, rresp, r, s;
  logic awready, wready, bvalid, arready, rvalid, press = 1'b0, pin, solar, load, aux, push, on2;
  int mismatches = 0, num_checks = 0, cyc = 0, t0;
  charge_switch_ctrl #(.relay_gap(200), .slow_gap(20)) i_charge_switch_ctrl (.ref_clk(ref_clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sense_closed_pin(pin),
    .solar_negative_switch(solar), .load_terminal(load), .aux_terminal(aux), .push_button(push));
  relay_model i_relay_model (.ref_clk(ref_clk), .coil(load), .press(press), .sense_closed_pin(pin),
    .on_second(on2));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    cyc <= cyc + 1;
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] ctrl_word(input logic [1:0] sv, input logic [3:0] lv, input logic [3:0] av,
    input logic [1:0] mv, input logic [2:0] pv, input logic fv);
    return {16'h0000, fv, pv, mv, av, lv, sv};
  endfunction : ctrl_word
  task automatic axi_write(input logic [11:0] ad, input logic [31:0] dv, output logic [1:0] rs);
    int n;
    rs = 2'h1;
    @(posedge ref_clk);
    awaddr <= ad;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 100)
      mismatches++;
  endtask : axi_write
  task automatic axi_read(input logic [11:0] ad, output logic [31:0] dv, output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    dv = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 100)
      mismatches++;
  endtask : axi_read
  task automatic wait_load(input logic v);
    for (int n = 0; n < 600 && load !== v; n++)
      @(posedge ref_clk);
  endtask : wait_load
  task automatic wait_solar(input logic v);
    for (int n = 0; n < 600 && solar !== v; n++)
      @(posedge ref_clk);
  endtask : wait_solar
  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end
  initial
  begin
    void'($urandom(56593));
    repeat (20) @(posedge ref_clk);
    check(32'({solar, load, aux, push, bvalid, rvalid}), 32'h0);
    rstn <= 1'b1;
    axi_read(addr_ctrl, d, r);
    check(d, 32'h0000_0C84);
    check(32'(r), 32'(resp_okay));
    axi_read(12'h010, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(resp_slverr));
    axi_write(12'h010, 32'hFFFF_FFFF, r);
    check(32'(r), 32'(resp_slverr));
    axi_write(addr_ctrl, ctrl_word(2'h1, 4'h6, 4'h7, 2'h0, 3'h0, 1'b0), r);
    check(32'(r), 32'(resp_okay));
    axi_read(addr_ctrl, d, r);
    check(d, 32'h0000_0C84);
    axi_write(addr_ctrl, 32'h0000_4C84, r);
    s = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      l = 4'($urandom % 12);
      if (k >= 2 && l == fn_diversion_inv)
        l = fn_diversion;
      a = 4'($urandom % 12);
      if (k < 3)
        s = 2'(k);
      axi_write(addr_ctrl, ctrl_word(2'(k), l, a, 2'(k), 3'h4, 1'b0), r);
      axi_read(addr_ctrl, d, r);
      check(d, ctrl_word(s, l, a, 2'(k), 3'h4, 1'b0));
    end
    for (int k = 2; k >= 0; k -= 2)
    begin
      axi_write(addr_ctrl, ctrl_word(2'(k), 4'h1, 4'h2, 2'h0, 3'h4, 1'b0), r);
      press <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check(32'(push), 32'(k == 2));
      press <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
    axi_write(addr_setpoint, {12'h800, 12'h600, 8'h10}, r);
    axi_write(addr_measure, {8'h00, 12'h600, 12'h700}, r);
    axi_write(addr_ctrl, ctrl_word(2'h1, 4'h6, 4'h7, 2'h0, 3'h4, 1'b0), r);
    repeat (300) @(posedge ref_clk);
    check(32'({load, aux}), 32'h1);
    axi_write(addr_ctrl, ctrl_word(2'h1, 4'h6, 4'h7, 2'h0, 3'h4, 1'b1), r);
    wait_load(1'b1);
    t0 = cyc;
    @(posedge ref_clk);
    check(32'({load, aux, on2}), 32'h5);
    axi_read(addr_status, d, r);
    check(32'(d[1]), 32'h1);
    axi_write(addr_measure, {8'h00, 12'h5E0, 12'h700}, r);
    wait_load(1'b0);
    check(32'(cyc - t0 >= 200), 32'h1);
    check(32'({load, aux}), 32'h1);
    axi_write(addr_measure, {8'h00, 12'h600, 12'h700}, r);
    wait_solar(1'b0);
    t0 = cyc;
    check(32'(solar), 32'h0);
    axi_write(addr_measure, {8'h00, 12'h5E0, 12'h700}, r);
    wait_solar(1'b1);
    check(32'(cyc - t0 >= 20), 32'h1);
    check(32'(solar), 32'h1);
    axi_write(addr_measure, {8'h00, 12'h600, 12'h700}, r);
    wait_solar(1'b0);
    axi_write(addr_measure, {8'h00, 12'h5F8, 12'h700}, r);
    repeat (40) @(posedge ref_clk);
    check(32'(solar), 32'h0);
    axi_write(addr_measure, {8'h00, 12'h5E0, 12'h700}, r);
    repeat (4) @(posedge ref_clk);
    check(32'(solar), 32'h1);
    // first pwm period has zero duty, so pwm_on stays low: PWM-driven solar reads off, PWM-driven load diversion reads on
    axi_write(addr_ctrl, ctrl_word(2'h1, fn_diversion, fn_diversion, pwm_load, 3'h4, 1'b1), r);
    repeat (2) @(posedge ref_clk);
    check(32'({solar, load, aux}), 32'h6);
    axi_write(addr_ctrl, ctrl_word(2'h1, fn_diversion, fn_diversion, pwm_both, 3'h4, 1'b1), r);
    repeat (2) @(posedge ref_clk);
    check(32'({solar, load, aux}), 32'h2);
    axi_write(addr_ctrl, ctrl_word(2'h1, fn_diversion, fn_diversion, pwm_solar, 3'h4, 1'b1), r);
    repeat (2) @(posedge ref_clk);
    check(32'({solar, load, aux}), 32'h0);
    final_report();
  end
endmodule : test_charge_switch_and_aux_battery_control
